// ---- rtl/etf_tx_frame.sv ----
/*
 transmit frame sequencer: takes the buffer byte stream (control
 byte first), adds preamble, delimiter, padding and CRC, and feeds
 the PHY-side byte stream through a two-entry buffer.
 assumes an APB master and a buffer reader on CORE_CLK.
*/
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module etf_tx_frame
   import etf_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [3:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output      logic [31:0] PRDATA,
   output      logic        PREADY,
   output      logic        PSLVERR,
   input  wire logic        BUF_VALID,
   input  wire logic [7:0]  BUF_DATA,
   input  wire logic        BUF_LAST,
   output      logic        BUF_READY,
   output      logic        TX_VALID,
   output      logic [7:0]  TX_DATA,
   output      logic        TX_LAST,
   output      logic        TX_ERR,
   input  wire logic        TX_READY
);
   // register file
   logic [7:0]  mac_control_three;
   logic [15:0] max_frame_length_limit;
   logic        abort_seen;
   logic [15:0] frame_count;
   logic [3:0]  last_control;

   default clocking cb_core @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);

   wire apb_setup  = PSEL && !PENABLE;
   wire apb_access = PSEL && PENABLE;
   wire hit_cfg    = (PADDR == ADDR_MAC_CONTROL_THREE);
   wire hit_max    = (PADDR == ADDR_MAX_FRAME_LENGTH);
   wire hit_stat   = (PADDR == ADDR_STATUS);
   wire hit_last   = (PADDR == ADDR_LAST_CONTROL);
   wire hit_any    = hit_cfg || hit_max || hit_stat || hit_last;
   wire wr_cfg     = apb_access && PWRITE && hit_cfg;
   wire wr_max     = apb_access && PWRITE && hit_max;
   wire wr_stat    = apb_access && PWRITE && hit_stat;

   wire        tx_enable = mac_control_three[CFG_ENABLE_BIT];
   wire [2:0]  global_pad_crc_config =
      mac_control_three[CFG_PAD_MSB:CFG_PAD_LSB]; // [RULE10]
   wire        global_huge_frame_enable =
      mac_control_three[CFG_HUGE_BIT]; // [RULE11]
   wire        global_pad = global_pad_crc_config[PADCFG_PAD_BIT];
   wire        global_crc = |global_pad_crc_config;

   // sequencer state
   etf_state_t  state;
   etf_state_t  next_state;
   logic [15:0] cnt;
   logic [31:0] crc;
   logic        frame_override_select;
   logic        frame_crc_enable;
   logic        frame_pad_enable;
   logic        frame_huge_allow;
   logic        body_empty;
   logic        eff_pad;
   logic        eff_crc;
   logic        eff_huge;

   function automatic logic [31:0] crc_step(input logic [31:0] c,
                                            input logic [7:0]  d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // push side of the output buffer
   logic       push_valid;
   logic [7:0] push_data;
   logic       push_last;
   logic       push_err;
   logic       push_ready;
   wire        push_fire = push_valid && push_ready;

   wire        take_ctrl = (state == ETF_IDLE) && tx_enable && BUF_VALID;
   wire        body_fire = (state == ETF_BODY) && BUF_VALID && push_ready;
   wire        drain_fire = (state == ETF_DRAIN) && BUF_VALID;
   wire [15:0] cnt_inc   = cnt + 16'h0001;
   // pad only while the body stays short of the minimum
   wire        need_pad  = eff_pad && (cnt_inc < MIN_BODY_LEN); // [RULE6]
   wire        oversize  = !eff_huge && (cnt >= max_frame_length_limit);
   wire        empty_pad = eff_pad && (MIN_BODY_LEN != 16'h0000);
   wire [31:0] crc_out   = ~crc;
   wire [1:0]  crc_idx   = cnt[1:0];

   // per-frame bits count only under override
   always_comb begin
      if (frame_override_select) begin
         eff_pad  = frame_pad_enable; // [RULE7]
         eff_crc  = frame_crc_enable; // [RULE12]
         eff_huge = frame_huge_allow; // [RULE13]
      end else begin
         eff_pad  = global_pad; // [RULE8]
         eff_crc  = global_crc;
         eff_huge = global_huge_frame_enable; // [RULE11]
      end
   end

   always_comb begin
      next_state = state;
      push_valid = 1'b0;
      push_data  = PAD_BYTE;
      push_last  = 1'b0;
      push_err   = 1'b0;
      BUF_READY  = 1'b0;
      unique case (state)
         ETF_IDLE: begin
            // control byte is consumed here, never pushed
            BUF_READY = tx_enable; // [RULE4]
            if (take_ctrl) next_state = ETF_PRE;
         end
         ETF_PRE: begin
            push_valid = 1'b1;
            push_data  = PREAMBLE_BYTE; // [RULE1]
            if (push_fire && cnt_inc == PREAMBLE_LEN)
               next_state = ETF_SFD;
         end
         ETF_SFD: begin
            push_valid = 1'b1;
            push_data  = SFD_BYTE; // [RULE1]
            push_last  = body_empty && !empty_pad && !eff_crc;
            if (push_fire) begin
               if (!body_empty)   next_state = ETF_BODY;
               else if (empty_pad) next_state = ETF_PAD;
               else if (eff_crc)  next_state = ETF_CRC;
               else               next_state = ETF_IDLE;
            end
         end
         ETF_BODY: begin
            BUF_READY  = push_ready;
            push_valid = BUF_VALID;
            push_data  = BUF_DATA; // [RULE3]
            if (oversize) begin
               push_last = 1'b1;
               push_err  = 1'b1; // [RULE13]
               if (body_fire) next_state = BUF_LAST ? ETF_IDLE : ETF_DRAIN;
            end else begin
               push_last = BUF_LAST && !need_pad && !eff_crc; // [RULE2]
               if (body_fire && BUF_LAST) begin
                  if (need_pad)     next_state = ETF_PAD;
                  else if (eff_crc) next_state = ETF_CRC;
                  else              next_state = ETF_IDLE;
               end
            end
         end
         ETF_PAD: begin
            push_valid = 1'b1;
            push_data  = PAD_BYTE; // [RULE6]
            push_last  = (cnt_inc == MIN_BODY_LEN) && !eff_crc;
            if (push_fire && cnt_inc == MIN_BODY_LEN)
               next_state = eff_crc ? ETF_CRC : ETF_IDLE;
         end
         ETF_CRC: begin
            push_valid = 1'b1;
            push_data  = crc_out[{crc_idx, 3'b000} +: 8]; // [RULE12]
            push_last  = (cnt_inc == CRC_LEN);
            if (push_fire && cnt_inc == CRC_LEN) next_state = ETF_IDLE;
         end
         ETF_DRAIN: begin
            BUF_READY = 1'b1;
            if (drain_fire && BUF_LAST) next_state = ETF_IDLE;
         end
         default: next_state = ETF_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state <= ETF_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // counter restarts on every phase change except body into padding,
   // where padding stops at a body total, not at a pad count
   wire keep_cnt = (state == ETF_BODY) && (next_state == ETF_PAD);
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         cnt <= 16'h0000;
      end else if (next_state != state && !keep_cnt) begin
         cnt <= 16'h0000;
      end else if (push_fire) begin
         cnt <= cnt_inc;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         crc <= CRC_INIT;
      end else if (state == ETF_SFD) begin
         crc <= CRC_INIT;
      end else if (push_fire && (state == ETF_BODY || state == ETF_PAD)) begin
         crc <= crc_step(crc, push_data);
      end
   end

   // settings snapshot per frame; global config is read live,
   // so software must not change it while a frame is in flight
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         frame_override_select <= 1'b0;
         frame_crc_enable      <= 1'b0;
         frame_pad_enable      <= 1'b0;
         frame_huge_allow      <= 1'b0;
         body_empty            <= 1'b0;
      end else if (take_ctrl) begin // [RULE9]
         frame_override_select <= BUF_DATA[CB_OVERRIDE_BIT]; // [RULE5]
         frame_crc_enable      <= BUF_DATA[CB_CRC_BIT];
         frame_pad_enable      <= BUF_DATA[CB_PAD_BIT];
         frame_huge_allow      <= BUF_DATA[CB_HUGE_BIT];
         body_empty            <= BUF_LAST;
      end
   end

   // registers; abort set wins over software clear
   wire abort_set = body_fire && oversize;
   wire frame_end = push_fire && push_last;
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         mac_control_three      <= 8'h00;
         max_frame_length_limit <= MAX_LEN_RESET;
         abort_seen             <= 1'b0;
         frame_count            <= 16'h0000;
         last_control           <= 4'h0;
      end else begin
         if (wr_cfg) mac_control_three <= PWDATA[7:0];
         if (wr_max) max_frame_length_limit <= PWDATA[15:0];
         if (abort_set) abort_seen <= 1'b1;
         else if (wr_stat && PWDATA[ST_ABORT_BIT]) abort_seen <= 1'b0;
         if (frame_end) frame_count <= frame_count + 16'h0001;
         if (take_ctrl) last_control <= BUF_DATA[3:0]; // [RULE5]
      end
   end

   wire [31:0] rd_cfg  = {24'h000000, mac_control_three};
   wire [31:0] rd_max  = {16'h0000, max_frame_length_limit};
   wire [31:0] rd_stat = {frame_count, 14'h0000, abort_seen,
                          state != ETF_IDLE};
   wire [31:0] rd_last = {28'h0000000, last_control};
   wire [31:0] rd_mux  = hit_cfg  ? rd_cfg  :
                         hit_max  ? rd_max  :
                         hit_stat ? rd_stat :
                         hit_last ? rd_last : 32'h00000000;

   // read data captured in setup, so access completes at once
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         PRDATA <= 32'h00000000;
      end else if (apb_setup) begin
         PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
      end
   end

   assign PREADY  = 1'b1;
   assign PSLVERR = apb_access && !hit_any;

   logic [9:0] out_word;
   etf_skid #(
      .WIDTH(10)
   ) u_skid (
      .clk       (CORE_CLK),
      .rst       (RST),
      .in_valid  (push_valid),
      .in_data   ({push_err, push_last, push_data}),
      .in_ready  (push_ready),
      .out_valid (TX_VALID),
      .out_data  (out_word),
      .out_ready (TX_READY)
   );
   assign TX_DATA = out_word[7:0];
   assign TX_LAST = out_word[8];
   assign TX_ERR  = out_word[9];

   a_pre_bytes: assert property ( // [RULE1]
      (state == ETF_PRE && push_fire) |-> push_data == PREAMBLE_BYTE
         ##0 cnt < PREAMBLE_LEN)
      else $error("preamble byte or count wrong");
   a_sfd_follows: assert property ( // [RULE1]
      (state == ETF_PRE && next_state != ETF_PRE)
         |-> cnt_inc == PREAMBLE_LEN ##1 state == ETF_SFD)
      else $error("delimiter did not follow preamble");
   a_ctrl_consumed: assert property ( // [RULE4]
      (state == ETF_IDLE) |-> !push_valid)
      else $error("control byte pushed");
   a_ctrl_decode: assert property ( // [RULE5]
      take_ctrl |=> frame_pad_enable == $past(BUF_DATA[CB_PAD_BIT])
         && frame_huge_allow == $past(BUF_DATA[CB_HUGE_BIT]))
      else $error("control byte decode wrong");
   a_pad_bound: assert property ( // [RULE6]
      (state == ETF_PAD && push_fire && push_last)
         |-> cnt_inc == MIN_BODY_LEN)
      else $error("padding length wrong");
   a_no_pad: assert property ( // [RULE7]
      (frame_override_select && !frame_pad_enable) |-> state != ETF_PAD)
      else $error("padding under override clear");
   a_global_rule: assert property ( // [RULE8]
      !frame_override_select |-> eff_crc == (|global_pad_crc_config)
         && eff_huge == global_huge_frame_enable)
      else $error("per-frame bit leaked");
   a_crc_length: assert property ( // [RULE12]
      (state == ETF_CRC && push_fire && push_last) |-> cnt == 16'h0003)
      else $error("crc length wrong");
   a_no_crc: assert property ( // [RULE2]
      !eff_crc |-> state != ETF_CRC)
      else $error("crc without request");
   a_giant_abort: assert property ( // [RULE13]
      (body_fire && !eff_huge && cnt >= max_frame_length_limit)
         |-> push_err && push_last ##1 abort_seen)
      else $error("oversize frame not aborted");
   a_body_pass: assert property ( // [RULE3]
      body_fire |-> push_data == BUF_DATA)
      else $error("body byte altered");

   c_padded: cover property (state == ETF_PAD ##1 state == ETF_CRC);
   c_abort: cover property (abort_set);
   c_plain: cover property (
      state == ETF_BODY && body_fire && push_last && !push_err);
   c_stall: cover property (push_valid && !push_ready);
endmodule

// ---- rtl/etf_pkg.sv ----
/*
 transmit frame control constants: register map, field positions,
 control byte layout, frame figures and sequencer states.
 assumes an APB master on the core clock.
*/
// Contract
// [RULE1] the block itself sends seven preamble bytes and the start delimiter before every frame body.
// [RULE2] zero padding and a generated CRC are added only when the active setting asks, else the body goes out unchanged.
// [RULE3] software supplies destination, source, type/length and payload in the buffer stream.
// [RULE4] exactly one control byte leads each frame and it is consumed, never sent.
// [RULE5] control byte bit 0 is override, bit 1 CRC, bit 2 padding, bit 3 huge frame, bits 7 to 4 read as zero.
// [RULE6] with override and padding set a body shorter than 60 bytes is zero-extended to exactly 60 bytes before the CRC.
// [RULE7] with override set and padding clear no padding is ever added.
// [RULE8] with override clear the per-frame bits are ignored and the global setting decides.
// [RULE9] software should finish configuration before it asks for any transmission.
// [RULE10] the global pad and CRC field sits in bits 7 to 5 of the third MAC control register.
// [RULE11] the global huge frame enable is bit 2 of that register and allows oversize frames when not overridden.
// [RULE12] with override and CRC set a 32-bit CRC is appended, with CRC clear nothing is appended.
// [RULE13] with huge frame clear a frame is aborted once it passes the maximum length, with it set it goes whole.
package etf_pkg;
   localparam logic [3:0]  ADDR_MAC_CONTROL_THREE = 4'h0;
   localparam logic [3:0]  ADDR_MAX_FRAME_LENGTH  = 4'h4;
   localparam logic [3:0]  ADDR_STATUS            = 4'h8;
   localparam logic [3:0]  ADDR_LAST_CONTROL      = 4'hc;
   localparam int          CFG_ENABLE_BIT         = 0;
   localparam int          CFG_HUGE_BIT           = 2;
   localparam int          CFG_PAD_LSB            = 5;
   localparam int          CFG_PAD_MSB            = 7;
   localparam int          PADCFG_PAD_BIT         = 0;
   localparam int          CB_OVERRIDE_BIT        = 0;
   localparam int          CB_CRC_BIT             = 1;
   localparam int          CB_PAD_BIT             = 2;
   localparam int          CB_HUGE_BIT            = 3;
   localparam int          ST_BUSY_BIT            = 0;
   localparam int          ST_ABORT_BIT           = 1;
   localparam int          ST_COUNT_LSB           = 16;
   localparam logic [15:0] MAX_LEN_RESET          = 16'h05ee;
   localparam logic [15:0] MIN_BODY_LEN           = 16'h003c;
   localparam logic [15:0] PREAMBLE_LEN           = 16'h0007;
   localparam logic [15:0] CRC_LEN                = 16'h0004;
   localparam logic [7:0]  PREAMBLE_BYTE          = 8'h55;
   localparam logic [7:0]  SFD_BYTE               = 8'hd5;
   localparam logic [7:0]  PAD_BYTE               = 8'h00;
   localparam logic [31:0] CRC_INIT               = 32'hffffffff;
   localparam logic [31:0] CRC_POLY               = 32'hedb88320;

   typedef enum logic [2:0] {
      ETF_IDLE  = 3'b000,
      ETF_PRE   = 3'b001,
      ETF_SFD   = 3'b010,
      ETF_BODY  = 3'b011,
      ETF_PAD   = 3'b100,
      ETF_CRC   = 3'b101,
      ETF_DRAIN = 3'b110
   } etf_state_t;
endpackage

// ---- rtl/etf_skid.sv ----
/*
 two-entry buffer with valid and ready on both sides.
 assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module etf_skid
   import etf_pkg::*;
#(
   parameter int WIDTH = 10
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             in_ready,
   output      logic             out_valid,
   output      logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   if (WIDTH < 1) begin : g_width_check
      $error("etf_skid: WIDTH must be positive");
   end

   logic [WIDTH-1:0] mem [2];
   logic             wr_ptr;
   logic             rd_ptr;
   logic [1:0]       fill;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         fill   <= 2'h0;
         mem[0] <= '0;
         mem[1] <= '0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= ~wr_ptr;
         end
         if (pop) rd_ptr <= ~rd_ptr;
         fill <= fill + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ---- testbench/etf_phy_model.sv ----
/*
 byte sink standing in for the PHY side of the transmit stream.
 assumes the valid/ready stream of etf_tx_frame on one clock.
*/
`timescale 1ns/1ps
module etf_phy_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       stall_en,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   input  wire logic       tx_err,
   output      logic       tx_ready,
   output      logic       seen,
   output      logic [9:0] seen_byte
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_ready <= 1'b0;
         seen <= 1'b0;
         seen_byte <= 10'h000;
      end else begin
         // slow medium: ready drops about a quarter of the time
         tx_ready <= stall_en ? (($urandom % 4) != 0) : 1'b1;
         seen <= tx_valid && tx_ready;
         seen_byte <= {tx_err, tx_last, tx_data};
      end
   end
endmodule

// ---- testbench/ethernet_tx_frame_control_tb.sv ----
/*
 self-checking bench for the transmit frame sequencer.
 assumes etf_tx_frame and the PHY sink model, one 200 MHz clock.
*/
`timescale 1ns/1ps
module ethernet_tx_frame_control_tb;
   import etf_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [3:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        buf_valid;
   logic [7:0]  buf_data;
   logic        buf_last;
   logic        buf_ready;
   logic        tx_valid;
   logic [7:0]  tx_data;
   logic        tx_last;
   logic        tx_err;
   logic        tx_ready;
   logic        stall_en;
   logic        seen;
   logic [9:0]  seen_byte;
   logic [9:0]  exp_q[$];
   int          error_cnt = 0;
   int          checks = 0;
   int          frames = 0;
   int          maxl = 1518;
   logic [31:0] rd;
   logic        e;

   always #2.5 core_clk = ~core_clk;

   etf_tx_frame etf_tx_frame_inst (
      .CORE_CLK(core_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .BUF_VALID(buf_valid),
      .BUF_DATA(buf_data), .BUF_LAST(buf_last), .BUF_READY(buf_ready),
      .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
      .TX_ERR(tx_err), .TX_READY(tx_ready));

   etf_phy_model etf_phy_model_inst (
      .clk(core_clk), .rst(rst), .stall_en(stall_en), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_err(tx_err),
      .tx_ready(tx_ready), .seen(seen), .seen_byte(seen_byte));

   task print_verdict;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic fail(input string msg);
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checks++;
      if (got !== exp)
         fail($sformatf("%s got %h want %h", what, got, exp));
   endtask

   function automatic logic [31:0] crc_step(input logic [31:0] c,
                                            input logic [7:0]  b);
      logic [31:0] r;
      r = c ^ {24'h0, b};
      for (int j = 0; j < 8; j++)
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      return r;
   endfunction

   task automatic apb(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd, output logic [31:0] rdat,
                      output logic err);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      if (pready !== 1'b1)
         fail("no pready");
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never reassigns psel at once
      @(posedge core_clk);
   endtask

   task automatic send(input logic [7:0] d, input logic last);
      int k;
      buf_valid <= 1'b1;
      buf_data <= d;
      buf_last <= last;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (buf_ready !== 1'b1 && k < 1000);
      if (buf_ready !== 1'b1)
         fail("buffer byte never taken");
      // an occasional gap so the sequencer sees a bubbly source
      if ($urandom % 3 == 0 || last) begin
         buf_valid <= 1'b0;
         @(posedge core_clk);
      end
   endtask

   task automatic frame(input logic [7:0] ctrl, input int len,
                        input logic [2:0] gcfg, input logic ghuge);
      logic [7:0]  b[$];
      logic [9:0]  t;
      logic        ov;
      logic        crc_on;
      logic        pad_on;
      logic        huge_on;
      logic        cut;
      logic [31:0] c;
      int          n;
      int          k;
      ov = ctrl[0];
      crc_on = ov ? ctrl[1] : (gcfg != 3'b000);
      pad_on = ov ? ctrl[2] : gcfg[0];
      huge_on = ov ? ctrl[3] : ghuge;
      apb(1'b1, ADDR_MAC_CONTROL_THREE,
          {24'h0, gcfg, 2'b00, ghuge, 1'b0, 1'b1}, rd, e);
      for (int i = 0; i < 7; i++)
         exp_q.push_back({2'b00, PREAMBLE_BYTE});
      exp_q.push_back({2'b00, SFD_BYTE});
      c = CRC_INIT;
      cut = 1'b0;
      for (int i = 0; i < len; i++) begin
         b.push_back(8'($urandom));
         if (!cut) begin
            cut = !huge_on && (i >= maxl);
            exp_q.push_back({cut, cut, b[i]});
            c = crc_step(c, b[i]);
         end
      end
      for (n = len; !cut && pad_on && n < int'(MIN_BODY_LEN); n++) begin
         exp_q.push_back({2'b00, PAD_BYTE});
         c = crc_step(c, PAD_BYTE);
      end
      for (int i = 0; i < 4 && !cut && crc_on; i++)
         exp_q.push_back({2'b00, ~c[8*i +: 8]});
      t = exp_q.pop_back();
      t[8] = 1'b1;
      exp_q.push_back(t);
      send(ctrl, len == 0);
      for (int i = 0; i < len; i++)
         send(b[i], i == len - 1);
      frames++;
      for (k = 0; exp_q.size() != 0 && k < 3000; k++)
         @(posedge core_clk);
      cmp(32'(exp_q.size()), 32'h0, "bytes missing");
      repeat (3) @(posedge core_clk);
      apb(1'b0, ADDR_LAST_CONTROL, 32'h0, rd, e);
      cmp(rd, {28'h0, ctrl[3:0]}, "last control byte");
   endtask

   always @(posedge core_clk) begin
      if (seen === 1'b1) begin
         if (exp_q.size() == 0)
            fail("unexpected tx byte");
         else
            cmp({22'h0, seen_byte}, {22'h0, exp_q.pop_front()},
                "tx byte");
      end
   end

   initial begin
      #(5.0 * 60000);
      fail("watchdog expired");
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 4'h0;
      pwdata = 32'h0;
      buf_valid = 1'b0;
      buf_data = 8'h00;
      buf_last = 1'b0;
      stall_en = 1'b0;
      void'($urandom(32'h5441));
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, ADDR_MAX_FRAME_LENGTH, 32'h0, rd, e);
      cmp(rd, {16'h0, MAX_LEN_RESET}, "max length reset");
      apb(1'b0, ADDR_STATUS, 32'h0, rd, e);
      cmp(rd, 32'h0, "status reset");
      apb(1'b0, 4'h2, 32'h0, rd, e);
      cmp({31'h0, e}, 32'h1, "unmapped error");
      // every low-nibble setting, noise in the unused top bits
      for (int i = 0; i < 16; i++) begin
         stall_en <= 1'($urandom);
         frame({4'($urandom), 4'(i)}, 14 + $urandom % 60,
               3'($urandom), 1'($urandom));
      end
      frame(8'h05, 59, 3'h0, 1'b0);
      frame(8'h05, 60, 3'h0, 1'b0);
      frame(8'h07, 0, 3'h0, 1'b0);
      frame(8'h01, 0, 3'h1, 1'b0);
      frame(8'h03, 9, 3'h1, 1'b0);
      frame(8'h00, 12, 3'h0, 1'b0);
      maxl = 20;
      apb(1'b1, ADDR_MAX_FRAME_LENGTH, 32'd20, rd, e);
      frame(8'h01, 25, 3'h1, 1'b1);
      frame(8'h09, 25, 3'h1, 1'b0);
      frame(8'h00, 25, 3'h1, 1'b1);
      frame(8'h00, 20, 3'h0, 1'b0);
      frame(8'h00, 21, 3'h0, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0, rd, e);
      cmp(rd, {16'(frames), 16'h0002}, "status after abort");
      apb(1'b1, ADDR_STATUS, 32'h2, rd, e);
      apb(1'b0, ADDR_STATUS, 32'h0, rd, e);
      cmp(rd, {16'(frames), 16'h0000}, "status cleared");
      print_verdict();
   end
endmodule
